/* include/rpm_defs.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the port monitor
// Assumes: 8-bit register space reached by the device's own I2C target logic
// Notes:   Definitions only
`ifndef RPM_DEFS_SVH
`define RPM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RPM_ADDR_PORT_SEL   8'h4C
`define RPM_ADDR_RATE_CTRL  8'h77
`define RPM_ADDR_MSG_A      8'h78
`define RPM_ADDR_MSG_B      8'h79
`define RPM_ADDR_ERR_FLAGS  8'h7A
`define RPM_ADDR_ERR_TALLY  8'h7B

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RPM_RATE_CTRL_RST   8'hC5
`define RPM_MSG_A_RST       8'h00
`define RPM_MSG_B_RST       8'h01
`define RPM_FLAGS_RST       4'h0
`define RPM_TALLY_RST       8'h00
`define RPM_TALLY_MAX       8'hFF
`define RPM_PORT_SEL_RST    8'h00
`define RPM_UNMAPPED_DATA   8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RPM_BAND_HI         7
`define RPM_BAND_LO         6
`define RPM_SETTLE_HI       5
`define RPM_SETTLE_LO       4
`define RPM_FLOOR_HI        3
`define RPM_FLOOR_LO        0
`define RPM_LEN_BIT         3
`define RPM_SUM_BIT         2
`define RPM_ECC2_BIT        1
`define RPM_ECC1_BIT        0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RPM_CLK_PERIOD_PS   5000
`define RPM_SETTLE_T0_NS    40000
`define RPM_SETTLE_T1_NS    80000
`define RPM_SETTLE_T2_NS    320000
`define RPM_SETTLE_T3_NS    1280000
// Least time, rounded up to whole cycles
`define RPM_NS_TO_CYC(t)    (((t) * 1000 + `RPM_CLK_PERIOD_PS - 1) / `RPM_CLK_PERIOD_PS)

`endif

/* include/rpm_pkg.sv */
// Purpose: Types shared by the port monitor files
// Assumes: Nothing
// Notes:   Constants live in rpm_defs.svh
package rpm_pkg;

  typedef logic [7:0] rpm_byte_t;

  typedef enum logic [2:0] {
    RPM_SEL_NONE  = 3'b000,
    RPM_SEL_PORT  = 3'b001,
    RPM_SEL_RATE  = 3'b010,
    RPM_SEL_MSG_A = 3'b011,
    RPM_SEL_MSG_B = 3'b100,
    RPM_SEL_FLAGS = 3'b101,
    RPM_SEL_TALLY = 3'b110
  } rpm_reg_sel_t;

endpackage

/* verilog/rpm_rate_monitor.sv */
// Purpose: Recovered clock rate tracker for one receive port
// Assumes: meas_mhz arrives with a one-cycle meas_valid pulse
// Notes:   Too-slow reads high until the first measurement arrives
`timescale 1ns/10ps
`include "rpm_defs.svh"

module rpm_rate_monitor #(
  parameter int CNT_W = 18,
  parameter int CYC0  = 8000,
  parameter int CYC1  = 16000,
  parameter int CYC2  = 64000,
  parameter int CYC3  = 256000
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic [1:0]       band,
  input  wire logic [1:0]       settle_sel,
  input  wire logic [3:0]       floor_mhz,
  input  wire logic             meas_valid,
  input  wire logic [7:0]       meas_mhz,
  output logic      [7:0]       rate_mhz,
  output logic                  stable,
  output logic                  too_slow
);

  logic [7:0]       rate_q, rate_d;
  logic             have_q, have_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, target;
  logic             stable_q, stable_d;
  logic             slow_q, slow_d;
  logic [7:0]       diff;
  logic             capture;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (settle_sel)
      2'b00: target = CNT_W'(CYC0);
      2'b01: target = CNT_W'(CYC1);
      2'b10: target = CNT_W'(CYC2);
      2'b11: target = CNT_W'(CYC3);
    endcase
    diff = (meas_mhz > rate_q) ? (meas_mhz - rate_q) : (rate_q - meas_mhz);
    capture = meas_valid && (!have_q || (diff > {6'h00, band}));
    rate_d  = capture ? meas_mhz : rate_q;
    have_d  = have_q | meas_valid;
    if (capture) begin
      cnt_d = '0;
    end else if (cnt_q != {CNT_W{1'b1}}) begin
      cnt_d = cnt_q + CNT_W'(1);
    end else begin
      cnt_d = cnt_q;
    end
    stable_d = have_q && !capture && (cnt_d >= target);
    slow_d = have_d ? (rate_d < {4'h0, floor_mhz}) : 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rate_q   <= 8'h00;
      have_q   <= 1'b0;
      cnt_q    <= '0;
      stable_q <= 1'b0;
      slow_q   <= 1'b1;
    end else begin
      rate_q   <= rate_d;
      have_q   <= have_d;
      cnt_q    <= cnt_d;
      stable_q <= stable_d;
      slow_q   <= slow_d;
    end
  end

  assign rate_mhz = rate_q;
  assign stable   = stable_q;
  assign too_slow = slow_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_band_hold: assert property (@(posedge clock) disable iff (reset)
    meas_valid && have_q && (diff <= {6'h00, band}) |=> rate_q == $past(rate_q))
    else $error("Rate changed inside hysteresis band");

  a_settle_min: assert property (@(posedge clock) disable iff (reset)
    stable_q && $stable(settle_sel) |-> (cnt_q >= target) && have_q)
    else $error("Stable raised before settle time");

  a_floor_flag: assert property (@(posedge clock) disable iff (reset)
    have_q && $stable(floor_mhz) |-> slow_q == (rate_q < {4'h0, floor_mhz}))
    else $error("Too-slow flag disagrees with floor");

endmodule // rpm_rate_monitor

/* verilog/rpm_port_regs.sv */
// Purpose: Per-port rate monitor control, message bytes and CSI error status
// Assumes: Register reads and writes come as one-cycle strobes from the I2C target
// Notes:   Read data answers one cycle after the read strobe
`timescale 1ns/10ps
`include "rpm_defs.svh"

// Notes on behaviour
// - Stored rate changes only beyond hysteresis band, or on the first measurement
// - Stable after rate holds for selected time
// - Too slow when rate below floor
// - Two message bytes, plain storage, reset 00/01
// - Sticky length error bit 3, read clears
// - Sticky checksum error bit 2, read clears
// - Sticky multi-bit ECC bit 1, read clears
// - Sticky corrected ECC bit 0, read clears
// - Errored packet tally, read clears
// - Port select steers port-specific accesses
module rpm_port_regs #(
  parameter int NPORT = 2,
  parameter int CYC0  = `RPM_NS_TO_CYC(`RPM_SETTLE_T0_NS),
  parameter int CYC1  = `RPM_NS_TO_CYC(`RPM_SETTLE_T1_NS),
  parameter int CYC2  = `RPM_NS_TO_CYC(`RPM_SETTLE_T2_NS),
  parameter int CYC3  = `RPM_NS_TO_CYC(`RPM_SETTLE_T3_NS)
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [7:0]         reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic [NPORT-1:0]   pkt_done,
  input  wire logic [NPORT-1:0]   pkt_len_err,
  input  wire logic [NPORT-1:0]   pkt_sum_err,
  input  wire logic [NPORT-1:0]   pkt_header_multibit_fault_flag,
  input  wire logic [NPORT-1:0]   pkt_header_fixed_bit_flag,
  input  wire logic [NPORT-1:0]   meas_valid,
  input  wire logic [NPORT*8-1:0] meas_mhz,
  output logic      [NPORT*8-1:0] rate_mhz,
  output logic      [NPORT-1:0]   rate_stable,
  output logic      [NPORT-1:0]   rate_too_slow
);

  localparam int SEL_W = (NPORT > 1) ? $clog2(NPORT) : 1;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  rpm_pkg::rpm_byte_t  ctrl_q   [NPORT];
  rpm_pkg::rpm_byte_t  ctrl_d   [NPORT];
  rpm_pkg::rpm_byte_t  msg_a_q  [NPORT];
  rpm_pkg::rpm_byte_t  msg_a_d  [NPORT];
  rpm_pkg::rpm_byte_t  msg_b_q  [NPORT];
  rpm_pkg::rpm_byte_t  msg_b_d  [NPORT];
  logic [3:0]          flags_q  [NPORT];
  logic [3:0]          flags_d  [NPORT];
  rpm_pkg::rpm_byte_t  tally_q  [NPORT];
  rpm_pkg::rpm_byte_t  tally_d  [NPORT];
  logic [SEL_W-1:0]    psel_q, psel_d;
  rpm_pkg::rpm_byte_t  rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d;
  rpm_pkg::rpm_reg_sel_t sel;
  logic [NPORT-1:0]    pkt_bad;
  logic [NPORT-1:0]    clr_flags;
  logic [NPORT-1:0]    clr_tally;
  logic [3:0]          ev_bits  [NPORT];

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      `RPM_ADDR_PORT_SEL:  sel = rpm_pkg::RPM_SEL_PORT;
      `RPM_ADDR_RATE_CTRL: sel = rpm_pkg::RPM_SEL_RATE;
      `RPM_ADDR_MSG_A:     sel = rpm_pkg::RPM_SEL_MSG_A;
      `RPM_ADDR_MSG_B:     sel = rpm_pkg::RPM_SEL_MSG_B;
      `RPM_ADDR_ERR_FLAGS: sel = rpm_pkg::RPM_SEL_FLAGS;
      `RPM_ADDR_ERR_TALLY: sel = rpm_pkg::RPM_SEL_TALLY;
      default:             sel = rpm_pkg::RPM_SEL_NONE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Per-port registers
  // --------------------------------------------------------------------------
  always_comb begin
    psel_d = psel_q;
    if (reg_write && sel == rpm_pkg::RPM_SEL_PORT) begin
      psel_d = reg_wdata[SEL_W-1:0];
    end
    for (int p = 0; p < NPORT; p++) begin
      ctrl_d[p]  = ctrl_q[p];
      msg_a_d[p] = msg_a_q[p];
      msg_b_d[p] = msg_b_q[p];
      if (reg_write && psel_q == SEL_W'(p)) begin
        if (sel == rpm_pkg::RPM_SEL_RATE) ctrl_d[p] = reg_wdata;
        if (sel == rpm_pkg::RPM_SEL_MSG_A) msg_a_d[p] = reg_wdata;
        if (sel == rpm_pkg::RPM_SEL_MSG_B) msg_b_d[p] = reg_wdata;
      end
      clr_flags[p] = reg_read && sel == rpm_pkg::RPM_SEL_FLAGS && psel_q == SEL_W'(p);
      clr_tally[p] = reg_read && sel == rpm_pkg::RPM_SEL_TALLY && psel_q == SEL_W'(p);
      ev_bits[p] = 4'h0;
      ev_bits[p][`RPM_LEN_BIT]  = pkt_done[p] & pkt_len_err[p];
      ev_bits[p][`RPM_SUM_BIT]  = pkt_done[p] & pkt_sum_err[p];
      ev_bits[p][`RPM_ECC2_BIT] = pkt_done[p] & pkt_header_multibit_fault_flag[p];
      ev_bits[p][`RPM_ECC1_BIT] = pkt_done[p] & pkt_header_fixed_bit_flag[p];
      // New events win over the clearing read so none is lost
      flags_d[p] = (clr_flags[p] ? 4'h0 : flags_q[p]) | ev_bits[p];
      pkt_bad[p] = |ev_bits[p];
      if (clr_tally[p]) begin
        tally_d[p] = pkt_bad[p] ? 8'h01 : `RPM_TALLY_RST;
      end else if (pkt_bad[p] && tally_q[p] != `RPM_TALLY_MAX) begin
        tally_d[p] = tally_q[p] + 8'h01;
      end else begin
        tally_d[p] = tally_q[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      psel_q <= '0;
      for (int p = 0; p < NPORT; p++) begin
        ctrl_q[p]  <= `RPM_RATE_CTRL_RST;
        msg_a_q[p] <= `RPM_MSG_A_RST;
        msg_b_q[p] <= `RPM_MSG_B_RST;
        flags_q[p] <= `RPM_FLAGS_RST;
        tally_q[p] <= `RPM_TALLY_RST;
      end
    end else begin
      psel_q <= psel_d;
      for (int p = 0; p < NPORT; p++) begin
        ctrl_q[p]  <= ctrl_d[p];
        msg_a_q[p] <= msg_a_d[p];
        msg_b_q[p] <= msg_b_d[p];
        flags_q[p] <= flags_d[p];
        tally_q[p] <= tally_d[p];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  always_comb begin
    rvalid_d = reg_read;
    rdata_d  = rdata_q;
    if (reg_read) begin
      unique case (sel)
        rpm_pkg::RPM_SEL_PORT:  rdata_d = 8'(psel_q);
        rpm_pkg::RPM_SEL_RATE:  rdata_d = ctrl_q[psel_q];
        rpm_pkg::RPM_SEL_MSG_A: rdata_d = msg_a_q[psel_q];
        rpm_pkg::RPM_SEL_MSG_B: rdata_d = msg_b_q[psel_q];
        rpm_pkg::RPM_SEL_FLAGS: rdata_d = {4'h0, flags_q[psel_q]};
        rpm_pkg::RPM_SEL_TALLY: rdata_d = tally_q[psel_q];
        rpm_pkg::RPM_SEL_NONE:  rdata_d = `RPM_UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  // --------------------------------------------------------------------------
  // Rate monitors, one per port
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    rpm_rate_monitor #(
      .CNT_W (18),
      .CYC0  (CYC0),
      .CYC1  (CYC1),
      .CYC2  (CYC2),
      .CYC3  (CYC3)
    ) u_rate (
      .clock      (clock),
      .reset      (reset),
      .band       (ctrl_q[g][`RPM_BAND_HI:`RPM_BAND_LO]),
      .settle_sel (ctrl_q[g][`RPM_SETTLE_HI:`RPM_SETTLE_LO]),
      .floor_mhz  (ctrl_q[g][`RPM_FLOOR_HI:`RPM_FLOOR_LO]),
      .meas_valid (meas_valid[g]),
      .meas_mhz   (meas_mhz[g*8 +: 8]),
      .rate_mhz   (rate_mhz[g*8 +: 8]),
      .stable     (rate_stable[g]),
      .too_slow   (rate_too_slow[g])
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_clear_flags;
      clr_flags[g] && !pkt_done[g];
    endsequence

    sequence s_clear_tally;
      clr_tally[g] && !pkt_bad[g];
    endsequence

    a_len_sticky: assert property (@(posedge clock) disable iff (reset)
      pkt_done[g] && pkt_len_err[g] ##1 !clr_flags[g] |=> flags_q[g][`RPM_LEN_BIT])
      else $error("Length flag not held");

    a_sum_set: assert property (@(posedge clock) disable iff (reset)
      pkt_done[g] && pkt_sum_err[g] |=> flags_q[g][`RPM_SUM_BIT])
      else $error("Checksum flag not set");

    a_ecc2_set: assert property (@(posedge clock) disable iff (reset)
      pkt_done[g] && pkt_header_multibit_fault_flag[g] |=> flags_q[g][`RPM_ECC2_BIT])
      else $error("Multi-bit flag not set");

    a_ecc1_set: assert property (@(posedge clock) disable iff (reset)
      pkt_done[g] && pkt_header_fixed_bit_flag[g] |=> flags_q[g][`RPM_ECC1_BIT])
      else $error("Corrected flag not set");

    a_flags_clear: assert property (@(posedge clock) disable iff (reset)
      s_clear_flags |=> flags_q[g] == 4'h0)
      else $error("Flags survived clearing read");

    a_tally_clear: assert property (@(posedge clock) disable iff (reset)
      s_clear_tally |=> tally_q[g] == 8'h00)
      else $error("Tally survived clearing read");

    a_tally_sat: assert property (@(posedge clock) disable iff (reset)
      tally_q[g] == 8'hFF && !clr_tally[g] |=> tally_q[g] == 8'hFF)
      else $error("Tally wrapped");

    a_tally_one: assert property (@(posedge clock) disable iff (reset)
      clr_tally[g] && pkt_bad[g] |=> tally_q[g] == 8'h01)
      else $error("Clear with error not one");
  end

  a_msg_reset: assert property (@(posedge clock)
    reset |=> msg_b_q[0] == 8'h01 && msg_a_q[0] == 8'h00)
    else $error("Message byte reset value wrong");

  a_read_route: assert property (@(posedge clock) disable iff (reset)
    reg_read && sel == rpm_pkg::RPM_SEL_MSG_A |=>
      reg_rvalid && reg_rdata == $past(msg_a_q[psel_q]))
    else $error("Read not steered to selected port");

endmodule // rpm_port_regs

/* verification/rpm_host_model.sv */
// Purpose: Host side model issuing register strobes to the port monitor
// Assumes: One-cycle strobes; read answer exactly one cycle later
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/10ps
`include "rpm_defs.svh"

module rpm_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  // ----------------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------------
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  // Idle cycle first, so no line is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    reg_addr = ~a;
    ok = (reg_rvalid === 1'b1);
    d = reg_rdata;
  endtask

  task automatic sel(input logic [7:0] p);
    wr(`RPM_ADDR_PORT_SEL, p);
  endtask
endmodule // rpm_host_model

/* verification/rpm_port_regs_test.sv */
// Purpose: Self-checking bench for the per-port monitor registers
// Assumes: Inputs change on the falling edge; settle counts shortened
// Notes:   Expected values come from the register table and settle counts
`timescale 1ns/10ps
`include "rpm_defs.svh"

module rpm_port_regs_test;
  localparam int C0 = 8;
  localparam int C1 = 16;
  localparam int C2 = 32;
  localparam int C3 = 64;
  logic        clock;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [1:0]  pkt_done;
  logic [1:0]  pkt_len_err;
  logic [1:0]  pkt_sum_err;
  logic [1:0]  pkt_header_multibit_fault_flag;
  logic [1:0]  pkt_header_fixed_bit_flag;
  logic [1:0]  meas_valid;
  logic [15:0] meas_mhz;
  logic [15:0] rate_mhz;
  logic [1:0]  rate_stable;
  logic [1:0]  rate_too_slow;
  int          fail_count;
  int          tests_run;

  // ----------------------------------------------------------------------------
  // Clock, instances
  // ----------------------------------------------------------------------------
  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  rpm_port_regs #(.NPORT(2), .CYC0(C0), .CYC1(C1), .CYC2(C2), .CYC3(C3)) u_rpm_port_regs (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pkt_done(pkt_done), .pkt_len_err(pkt_len_err),
    .pkt_sum_err(pkt_sum_err), .pkt_header_multibit_fault_flag(pkt_header_multibit_fault_flag), .pkt_header_fixed_bit_flag(pkt_header_fixed_bit_flag),
    .meas_valid(meas_valid), .meas_mhz(meas_mhz), .rate_mhz(rate_mhz),
    .rate_stable(rate_stable), .rate_too_slow(rate_too_slow));

  rpm_host_model u_rpm_host_model (
    .clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_rpm_host_model.rd(a, d, ok);
    chk1(ok, 1'b1, "read answer one cycle late");
    chk8(d, exp, "read data");
  endtask

  // Error qualifiers as {length, checksum, multi-bit, corrected}
  task automatic pkt(input int p, input logic [3:0] e);
    @(negedge clock);
    pkt_done[p] = 1'b1;
    {pkt_len_err[p], pkt_sum_err[p], pkt_header_multibit_fault_flag[p], pkt_header_fixed_bit_flag[p]} = e;
    @(negedge clock);
    pkt_done[p] = 1'b0;
    {pkt_len_err[p], pkt_sum_err[p], pkt_header_multibit_fault_flag[p], pkt_header_fixed_bit_flag[p]} = ~e;
  endtask

  task automatic meas(input int p, input logic [7:0] v);
    @(negedge clock);
    meas_valid[p] = 1'b1;
    meas_mhz[8*p +: 8] = v;
    @(negedge clock);
    meas_valid[p] = 1'b0;
    meas_mhz[8*p +: 8] = ~v;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    rdchk(`RPM_ADDR_RATE_CTRL, 8'hC5);
    rdchk(`RPM_ADDR_MSG_A, 8'h00);
    rdchk(`RPM_ADDR_MSG_B, 8'h01);
    rdchk(`RPM_ADDR_ERR_FLAGS, 8'h00);
    rdchk(`RPM_ADDR_ERR_TALLY, 8'h00);
    rdchk(8'h50, 8'h00);
    chk1(rate_too_slow[0], 1'b1, "too slow before measuring");
    chk1(rate_stable[0], 1'b0, "stable before measuring");
  endtask

  task automatic t_msg();
    u_rpm_host_model.wr(`RPM_ADDR_MSG_A, 8'hA5);
    u_rpm_host_model.wr(`RPM_ADDR_MSG_B, 8'h3C);
    u_rpm_host_model.wr(`RPM_ADDR_RATE_CTRL, 8'h05);
    u_rpm_host_model.sel(8'h03);
    rdchk(`RPM_ADDR_PORT_SEL, 8'h01);
    rdchk(`RPM_ADDR_MSG_A, 8'h00);
    rdchk(`RPM_ADDR_MSG_B, 8'h01);
    rdchk(`RPM_ADDR_RATE_CTRL, 8'hC5);
    u_rpm_host_model.wr(`RPM_ADDR_MSG_A, 8'h5A);
    u_rpm_host_model.sel(8'h00);
    rdchk(`RPM_ADDR_MSG_A, 8'hA5);
    rdchk(`RPM_ADDR_MSG_B, 8'h3C);
    rdchk(`RPM_ADDR_RATE_CTRL, 8'h05);
  endtask

  task automatic t_flags();
    for (int b = 0; b < 4; b++) begin
      pkt(1, 4'h1 << b);
      rdchk(`RPM_ADDR_ERR_FLAGS, 8'h00);
      u_rpm_host_model.sel(8'h01);
      rdchk(`RPM_ADDR_ERR_FLAGS, 8'h01 << b);
      rdchk(`RPM_ADDR_ERR_FLAGS, 8'h00);
      u_rpm_host_model.sel(8'h00);
    end
    u_rpm_host_model.sel(8'h01);
    pkt(1, 4'h0);
    pkt(1, 4'hF);
    u_rpm_host_model.wr(`RPM_ADDR_ERR_FLAGS, 8'h00);
    u_rpm_host_model.wr(`RPM_ADDR_ERR_TALLY, 8'h00);
    rdchk(`RPM_ADDR_ERR_FLAGS, 8'h0F);
    rdchk(`RPM_ADDR_ERR_TALLY, 8'h05);
    rdchk(`RPM_ADDR_ERR_TALLY, 8'h00);
  endtask

  task automatic t_tally();
    logic [7:0] d;
    logic       ok;
    repeat (260) pkt(1, 4'h4);
    // Clearing read lands on the same edge as a new error
    fork
      u_rpm_host_model.rd(`RPM_ADDR_ERR_TALLY, d, ok);
      pkt(1, 4'h8);
    join
    chk8(d, 8'hFF, "tally saturates");
    rdchk(`RPM_ADDR_ERR_TALLY, 8'h01);
    rdchk(`RPM_ADDR_ERR_FLAGS, 8'h0C);
    u_rpm_host_model.sel(8'h00);
    // First port gets its own packet, apart from the second port's history
    pkt(0, 4'h2);
    rdchk(`RPM_ADDR_ERR_FLAGS, 8'h02);
    rdchk(`RPM_ADDR_ERR_TALLY, 8'h01);
  endtask

  task automatic t_rate();
    u_rpm_host_model.wr(`RPM_ADDR_RATE_CTRL, 8'hC5);
    meas(0, 8'h32);
    chk8(rate_mhz[7:0], 8'h32, "first capture");
    chk1(rate_too_slow[0], 1'b0, "above floor");
    meas(0, 8'h35);
    chk8(rate_mhz[7:0], 8'h32, "in band high");
    meas(0, 8'h2F);
    chk8(rate_mhz[7:0], 8'h32, "in band low");
    meas(0, 8'h36);
    chk8(rate_mhz[7:0], 8'h36, "beyond band");
    u_rpm_host_model.wr(`RPM_ADDR_RATE_CTRL, 8'h05);
    meas(0, 8'h37);
    chk8(rate_mhz[7:0], 8'h37, "zero band");
    meas(0, 8'h04);
    chk1(rate_too_slow[0], 1'b1, "below floor");
    meas(0, 8'h05);
    chk1(rate_too_slow[0], 1'b0, "at floor");
    u_rpm_host_model.wr(`RPM_ADDR_RATE_CTRL, 8'h07);
    meas(0, 8'h06);
    chk1(rate_too_slow[0], 1'b1, "raised floor");
    chk8(rate_mhz[15:8], 8'h00, "other port untouched");
    // Second port keeps its reset control, so its floor is still 5
    meas(1, 8'h03);
    chk8(rate_mhz[15:8], 8'h03, "second port capture");
    chk1(rate_too_slow[1], 1'b1, "second port below floor");
    chk1(rate_stable[1], 1'b0, "second port not yet stable");
    chk8(rate_mhz[7:0], 8'h06, "first port kept");
  endtask

  task automatic t_settle();
    int cycs[4];
    int k;
    cycs = '{C0, C1, C2, C3};
    for (int s = 0; s < 4; s++) begin
      u_rpm_host_model.wr(`RPM_ADDR_RATE_CTRL, {2'b11, 2'(s), 4'h5});
      meas(0, (s % 2) ? 8'h64 : 8'hC8);
      @(negedge clock);
      k = 2;
      // In-band measurement midway must not restart the timer
      while (rate_stable[0] !== 1'b1 && k < cycs[s] + 4) begin
        // The measurement spends two falling edges, so count both
        if (s == 3 && k == 20) begin
          meas(0, 8'h65);
          k++;
        end else begin
          @(negedge clock);
        end
        k++;
      end
      chk1(rate_stable[0], 1'b1, "stable after settle time");
      chk1(1'(k >= cycs[s] && k <= cycs[s] + 2), 1'b1, "settle time length");
    end
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------------
  initial begin
    fail_count = 0;
    tests_run = 0;
    reset = 1'b1;
    pkt_done = 2'h0;
    pkt_len_err = 2'h0;
    pkt_sum_err = 2'h0;
    pkt_header_multibit_fault_flag = 2'h0;
    pkt_header_fixed_bit_flag = 2'h0;
    meas_valid = 2'h0;
    meas_mhz = 16'h0000;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    t_reset();
    t_msg();
    t_flags();
    t_tally();
    t_rate();
    t_settle();
    summarize();
  end

  initial begin
    #500000;
    fail_count++;
    summarize();
  end
endmodule // rpm_port_regs_test
